// ---- hdl/cpcc_pkg.sv ----
// How it works
// - Switch source only once new one ready, except failure fallback to fast RC
// - Four sources: crystal, user clock, fast, slow
// - Reset runs fast RC divided by eight
// - Source and divider writable right after reset
// - Programmable prescaler divides CPU/peripheral clock
// - Monitor falls back to fast RC over eight
// - Separate stops for core, peripherals, memory
// - Gate bit layout with reserved bits
// - Configurable clock copy on output pin
// - Wait stops CPU, peripherals keep running
// - Active halt stops CPU and peripheral clocks
// - Regulator-off active halt powers regulator down
// - Halt stops CPU, memory, peripheral clocks, regulator off, external wake
// - Slow RC routable to timer capture input
package cpcc_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_SEL = 8'h00;
  localparam logic [7:0] REG_PRESC = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_GATE_LO = 8'h0C;
  localparam logic [7:0] REG_GATE_HI = 8'h10;
  localparam logic [7:0] REG_PWR = 8'h14;
  // Select register fields
  localparam int SEL_SRC_LSB = 0;
  localparam int SEL_MON_BIT = 2;
  localparam int SEL_CAPT_BIT = 3;
  localparam int SEL_OUT_EN_BIT = 4;
  localparam int SEL_OUT_SRC_BIT = 5;
  localparam int SEL_MEM_OFF_BIT = 6;
  // Power register fields
  localparam int PWR_MODE_LSB = 0;
  localparam int PWR_REGOFF_BIT = 2;
  localparam int PWR_ENTER_BIT = 3;
  // Status register fields
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_FAIL_BIT = 3;
  localparam int STAT_MODE_LSB = 4;
  // Reset values and writable masks
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [2:0] PRESC_RST = 3'h3;
  localparam logic [7:0] GATE_LO_RST = 8'hFB;
  localparam logic [7:0] GATE_LO_MASK = 8'hFB;
  localparam logic [7:0] GATE_HI_RST = 8'h0C;
  localparam logic [7:0] GATE_HI_MASK = 8'h0C;
  // Failure monitor timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int FAIL_TIME_NS = 640;
  localparam int FAIL_CYCLES = FAIL_TIME_NS / CLK_PERIOD_NS;
  // Clock sources
  typedef enum logic [1:0] {
    SRC_FAST_RC = 2'b00,
    SRC_CRYSTAL = 2'b01,
    SRC_EXT_CLK = 2'b10,
    SRC_SLOW_RC = 2'b11
  } cpcc_src_t;
  // Power modes
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_WAIT = 2'b01,
    MODE_AHALT = 2'b10,
    MODE_HALT = 2'b11
  } cpcc_mode_t;
endpackage

// ---- hdl/cpcc_sw_if.sv ----
`timescale 1ns/100ps
// Link between the controller and its source switch
interface cpcc_sw_if;
  import cpcc_pkg::*;
  cpcc_src_t req_src; // Requested source
  cpcc_src_t cur_src; // Source in use
  logic mon_en; // Failure monitor enable
  logic busy; // Switch pending
  logic fail_pulse; // External clock lost
  logic sel_tick; // Tick of source in use
  modport sw (input req_src, mon_en, output cur_src, busy, fail_pulse, sel_tick);
  modport ctl (output req_src, mon_en, input cur_src, busy, fail_pulse, sel_tick);
endinterface

// ---- hdl/cpcc_src_switch.sv ----
`timescale 1ns/100ps
module cpcc_src_switch import cpcc_pkg::*; #(
  parameter int FAIL_LIMIT = FAIL_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Oscillators
  input wire logic [3:0] src_tick,
  input wire logic [3:0] src_ready,
  // Controller side
  cpcc_sw_if.sw sw
);
  if (FAIL_LIMIT < 2 || FAIL_LIMIT > 4096) begin : g_chk
    $error("FAIL_LIMIT out of range");
  end
  cpcc_src_t cur_q; // Source in use
  logic sel_q; // Registered tick
  logic fail_q; // Failure pulse
  logic [12:0] miss_q; // Cycles since last external tick
  logic go; // Switch at this edge
  logic watch; // External source monitored
  // Change only on a tick of the new, ready source: no runt pulse
  assign go = (sw.req_src != cur_q) && src_ready[sw.req_src] && src_tick[sw.req_src];
  assign watch = sw.mon_en && (cur_q == SRC_CRYSTAL || cur_q == SRC_EXT_CLK);
  assign sw.cur_src = cur_q;
  assign sw.busy = sw.req_src != cur_q;
  assign sw.sel_tick = sel_q;
  assign sw.fail_pulse = fail_q;
  // Source in use
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cur_q <= SRC_FAST_RC;
    end else if (fail_q) begin
      cur_q <= SRC_FAST_RC;
    end else if (go) begin
      cur_q <= sw.req_src;
    end
  end
  // Tick suppressed in the switching cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= 1'b0;
    end else begin
      sel_q <= src_tick[cur_q] && !go && !fail_q;
    end
  end
  // Missing-tick counter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      miss_q <= 13'h0000;
      fail_q <= 1'b0;
    end else begin
      fail_q <= 1'b0;
      if (!watch || src_tick[cur_q] || fail_q) begin
        miss_q <= 13'h0000;
      end else if (miss_q == 13'(FAIL_LIMIT - 1)) begin
        fail_q <= 1'b1;
        miss_q <= 13'h0000;
      end else begin
        miss_q <= miss_q + 13'h0001;
      end
    end
  end
  fail_to_fast_a: assert property (@(posedge clock) disable iff (!rst_n)
    fail_q |=> cur_q == SRC_FAST_RC && !sel_q)
    else $error("failure did not select fast RC");
  switch_ready_a: assert property (@(posedge clock) disable iff (!rst_n)
    ($changed(cur_q) && !$past(fail_q)) |-> $past(src_ready[sw.req_src]))
    else $error("switched to a source not ready");
endmodule

// ---- hdl/cpcc_prescaler.sv ----
`timescale 1ns/100ps
module cpcc_prescaler #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Ticks in and out
  input wire logic in_tick,
  input wire logic [W-1:0] ratio,
  output logic out_tick
);
  localparam int CW = 1 << W;
  if (W < 1 || W > 4) begin : g_chk
    $error("W out of range");
  end
  logic [CW-1:0] cnt_q; // Ticks counted
  logic [CW-1:0] lim; // Last count of a period
  logic out_q; // Divided tick
  assign lim = ~({CW{1'b1}} << ratio);
  assign out_tick = out_q;
  // Divide by two to the power of ratio
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      out_q <= 1'b0;
      if (in_tick) begin
        // Compare with >= so a ratio cut mid-period ends it at once
        if (cnt_q >= lim) begin
          cnt_q <= '0;
          out_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
  out_needs_in_a: assert property (@(posedge clock) disable iff (!rst_n)
    out_q |-> $past(in_tick) && $past(cnt_q >= lim))
    else $error("divided tick without input tick");
endmodule

// ---- hdl/cpcc_top.sv ----
`timescale 1ns/100ps
module cpcc_top import cpcc_pkg::*; #(
  parameter int FAIL_LIMIT = FAIL_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillators: 0 fast RC, 1 crystal, 2 user clock, 3 slow RC
  input wire logic [3:0] src_tick,
  input wire logic [3:0] src_ready,
  // Wakeup sources
  input wire logic irq_internal,
  input wire logic irq_external,
  input wire logic awu_irq,
  // Clock enables out
  output logic master_clock_tick,
  output logic cpu_tick,
  output logic mem_tick,
  output logic [7:0] periph_tick_low,
  output logic [7:0] periph_tick_high,
  // Pins and analog controls
  output logic clock_output,
  output logic regulator_on,
  output logic slow_rc_to_capture,
  output logic clock_fail
);
  cpcc_sw_if sw_if ();

  logic [7:0] sel_q; // Source and options
  logic [2:0] presc_q; // Divider exponent
  logic [7:0] gate_lo_q; // Peripheral gates, low
  logic [7:0] gate_hi_q; // Peripheral gates, high
  cpcc_mode_t mode_q; // Power mode
  logic regoff_q; // Regulator-off variant
  logic fail_flag_q; // Sticky failure flag
  logic [31:0] prdata_q; // Read data
  logic master_w; // Divided master tick
  logic master_q; // Registered master tick
  logic cpu_q; // CPU tick
  logic mem_q; // Memory tick
  logic [15:0] per_q; // Peripheral ticks
  logic out_q; // Clock output level
  logic reg_on_q; // Regulator state
  logic capt_q; // Routed slow RC
  logic wr; // Write access
  logic map_ok; // Address decodes
  logic [31:0] rd_mux; // Read data before register
  logic wake; // Wakeup for current mode
  logic out_src; // Clock output toggle source
  logic [15:0] gate_all; // Gates joined

  // Access phase write strobe
  assign wr = psel && penable && pwrite;

  // Address decode
  always_comb begin
    map_ok = 1'b1;
    case (paddr)
      REG_SEL, REG_PRESC, REG_STAT, REG_GATE_LO, REG_GATE_HI, REG_PWR: map_ok = 1'b1;
      default: map_ok = 1'b0;
    endcase
  end

  // Zero wait states; error only on unmapped word
  assign pready = 1'b1;
  assign pslverr = psel && penable && !map_ok;
  assign prdata = prdata_q;

  // Read mux, reserved bits read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      REG_SEL: rd_mux = {24'h00_0000, sel_q};
      REG_PRESC: rd_mux = {29'h0000_0000, presc_q};
      REG_STAT: begin
        rd_mux[1:0] = sw_if.cur_src;
        rd_mux[STAT_BUSY_BIT] = sw_if.busy;
        rd_mux[STAT_FAIL_BIT] = fail_flag_q;
        rd_mux[STAT_MODE_LSB +: 2] = mode_q;
      end
      REG_GATE_LO: rd_mux = {24'h00_0000, gate_lo_q};
      REG_GATE_HI: rd_mux = {24'h00_0000, gate_hi_q};
      REG_PWR: rd_mux = {29'h0000_0000, regoff_q, mode_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data caught in the setup cycle, stable through access
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  // Source select and options; failure overrides a same-cycle write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= SEL_RST;
    end else if (sw_if.fail_pulse) begin
      sel_q[SEL_SRC_LSB +: 2] <= SRC_FAST_RC;
    end else if (wr && paddr == REG_SEL) begin
      sel_q <= {1'b0, pwdata[6:0]};
    end
  end

  // Prescaler exponent; failure forces divide by eight
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= PRESC_RST;
    end else if (sw_if.fail_pulse) begin
      presc_q <= PRESC_RST;
    end else if (wr && paddr == REG_PRESC) begin
      presc_q <= pwdata[2:0];
    end
  end

  // Peripheral gate registers, reserved bits held at zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gate_lo_q <= GATE_LO_RST;
      gate_hi_q <= GATE_HI_RST;
    end else begin
      if (wr && paddr == REG_GATE_LO) begin
        gate_lo_q <= pwdata[7:0] & GATE_LO_MASK;
      end
      if (wr && paddr == REG_GATE_HI) begin
        gate_hi_q <= pwdata[7:0] & GATE_HI_MASK;
      end
    end
  end

  // Sticky failure flag, write one clears, set wins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fail_flag_q <= 1'b0;
    end else if (sw_if.fail_pulse) begin
      fail_flag_q <= 1'b1;
    end else if (wr && paddr == REG_STAT && pwdata[STAT_FAIL_BIT]) begin
      fail_flag_q <= 1'b0;
    end
  end

  // Wakeup sources allowed in each mode
  always_comb begin
    wake = 1'b0;
    case (mode_q)
      MODE_WAIT: wake = irq_internal || irq_external;
      MODE_AHALT: wake = awu_irq || irq_external;
      MODE_HALT: wake = irq_external;
      default: wake = 1'b0;
    endcase
  end

  // Power mode; wakeup returns to run and leaves clock settings alone
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= MODE_RUN;
      regoff_q <= 1'b0;
    end else if (mode_q != MODE_RUN) begin
      if (wake) begin
        mode_q <= MODE_RUN;
      end
    end else if (wr && paddr == REG_PWR) begin
      regoff_q <= pwdata[PWR_REGOFF_BIT];
      if (pwdata[PWR_ENTER_BIT]) begin
        mode_q <= cpcc_mode_t'(pwdata[PWR_MODE_LSB +: 2]);
      end
    end
  end

  // Source switch with failure monitor
  assign sw_if.req_src = cpcc_src_t'(sel_q[SEL_SRC_LSB +: 2]);
  assign sw_if.mon_en = sel_q[SEL_MON_BIT];
  cpcc_src_switch #(
    .FAIL_LIMIT(FAIL_LIMIT)
  ) u_switch (
    .clock(clock),
    .rst_n(rst_n),
    .src_tick(src_tick),
    .src_ready(src_ready),
    .sw(sw_if)
  );

  // Master clock divider
  cpcc_prescaler #(
    .W(3)
  ) u_presc (
    .clock(clock),
    .rst_n(rst_n),
    .in_tick(sw_if.sel_tick),
    .ratio(presc_q),
    .out_tick(master_w)
  );

  // Core and memory enables, run mode only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      master_q <= 1'b0;
      cpu_q <= 1'b0;
      mem_q <= 1'b0;
    end else begin
      master_q <= master_w;
      cpu_q <= master_w && mode_q == MODE_RUN;
      mem_q <= master_w && mode_q == MODE_RUN && !sel_q[SEL_MEM_OFF_BIT];
    end
  end

  // Per-peripheral enables; stopped in both halt modes
  assign gate_all = {gate_hi_q, gate_lo_q};
  for (genvar i = 0; i < 16; i++) begin : g_per
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        per_q[i] <= 1'b0;
      end else begin
        per_q[i] <= master_w && gate_all[i] && !mode_q[1];
      end
    end
  end

  // Clock output: master or raw source, halved to keep duty even
  assign out_src = sel_q[SEL_OUT_SRC_BIT] ? sw_if.sel_tick : master_w;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b0;
    end else if (!sel_q[SEL_OUT_EN_BIT]) begin
      out_q <= 1'b0;
    end else if (out_src) begin
      out_q <= !out_q;
    end
  end

  // Regulator control and slow RC routing to timer capture
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_on_q <= 1'b1;
      capt_q <= 1'b0;
    end else begin
      reg_on_q <= !(mode_q == MODE_HALT || (mode_q == MODE_AHALT && regoff_q));
      capt_q <= sel_q[SEL_CAPT_BIT] && src_tick[SRC_SLOW_RC];
    end
  end

  assign master_clock_tick = master_q;
  assign cpu_tick = cpu_q;
  assign mem_tick = mem_q;
  assign periph_tick_low = per_q[7:0];
  assign periph_tick_high = per_q[15:8];
  assign clock_output = out_q;
  assign regulator_on = reg_on_q;
  assign slow_rc_to_capture = capt_q;
  assign clock_fail = fail_flag_q;

  // Settled in wait for two cycles, internal interrupt in the second
  sequence wait_held_s;
    mode_q == MODE_WAIT ##1 mode_q == MODE_WAIT;
  endsequence
  sequence int_irq_s;
    irq_internal && mode_q == MODE_WAIT;
  endsequence

  cpu_stops_a: assert property (@(posedge clock) disable iff (!rst_n)
    mode_q != MODE_RUN |=> !cpu_q)
    else $error("CPU tick outside run mode");
  wait_periph_a: assert property (@(posedge clock) disable iff (!rst_n)
    (mode_q == MODE_WAIT && master_w) |=> per_q[7:0] == $past(gate_lo_q))
    else $error("peripheral stopped in wait");
  halt_periph_a: assert property (@(posedge clock) disable iff (!rst_n)
    mode_q[1] |=> per_q == 16'h0000)
    else $error("peripheral tick in halt");
  halt_reg_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    mode_q == MODE_HALT |=> !reg_on_q)
    else $error("regulator on in halt");
  ahalt_reg_a: assert property (@(posedge clock) disable iff (!rst_n)
    mode_q == MODE_AHALT |=> reg_on_q == !$past(regoff_q))
    else $error("regulator wrong in active halt");
  halt_wake_a: assert property (@(posedge clock) disable iff (!rst_n)
    (mode_q == MODE_HALT && irq_external) |=> mode_q == MODE_RUN)
    else $error("no wake from halt");
  wait_wake_a: assert property (@(posedge clock) disable iff (!rst_n)
    wait_held_s ##0 int_irq_s |=> mode_q == MODE_RUN)
    else $error("no wake from wait");
  wake_keeps_a: assert property (@(posedge clock) disable iff (!rst_n)
    (mode_q != MODE_RUN && wake && !sw_if.fail_pulse) |=> $stable(presc_q) && $stable(sel_q))
    else $error("wakeup changed clock settings");
  fail_div8_a: assert property (@(posedge clock) disable iff (!rst_n)
    sw_if.fail_pulse |=> presc_q == PRESC_RST && sel_q[1:0] == SRC_FAST_RC && fail_flag_q)
    else $error("failure did not force fast RC over eight");
  gate_rsvd_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wr && paddr == REG_GATE_LO) |=> gate_lo_q == ($past(pwdata[7:0]) & GATE_LO_MASK))
    else $error("gate write wrong");
endmodule

// ---- tb/cpcc_osc_model.sv ----
`timescale 1ns/100ps
// Four oscillators seen as tick pulses on the system clock
module cpcc_osc_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Run control from the bench
  input wire logic [3:0] run_en,
  // Oscillator outputs
  output logic [3:0] src_tick,
  output logic [3:0] src_ready
);
  // Periods: fast RC, crystal, user clock, slow RC
  localparam int PER [4] = '{2, 3, 4, 16};
  int ph_q [4]; // Phase counters
  int st_q [4]; // Startup tick counters
  // A stopped oscillator neither ticks nor claims ready
  always @(posedge clock or negedge rst_n) begin
    for (int i = 0; i < 4; i++) begin
      if (!rst_n || !run_en[i]) begin
        ph_q[i] <= 0;
        st_q[i] <= 0;
        src_tick[i] <= 1'b0;
        src_ready[i] <= 1'b0;
      end else begin
        // Ready only after a few ticks, like a real startup
        ph_q[i] <= (ph_q[i] == PER[i] - 1) ? 0 : ph_q[i] + 1;
        src_tick[i] <= (ph_q[i] == PER[i] - 1);
        if (ph_q[i] == PER[i] - 1 && st_q[i] < 4) st_q[i] <= st_q[i] + 1;
        src_ready[i] <= (st_q[i] == 4);
      end
    end
  end
endmodule

// ---- tb/test_clock_power_controller.sv ----
`timescale 1ns/100ps
module test_clock_power_controller import cpcc_pkg::*;;
  // Power mode table: wait, active halt, regulator-off halt, halt
  localparam logic [7:0] PW [4] = '{8'h09, 8'h0A, 8'h0E, 8'h0B};
  localparam logic [2:0] BAD [4] = '{3'h4, 3'h1, 3'h1, 3'h5};
  localparam logic [2:0] GOOD [4] = '{3'h1, 3'h4, 3'h2, 3'h2};
  localparam logic [3:0] PER_ON = 4'h1;
  localparam logic [3:0] REG_KEEP = 4'h3;
  localparam int SPER [4] = '{2, 3, 4, 16};
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, er_v;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [3:0] osc_en, src_tick, src_ready;
  logic irq_internal, irq_external, awu_irq;
  logic master_clock_tick, cpu_tick, mem_tick, clock_output;
  logic regulator_on, slow_rc_to_capture, clock_fail;
  logic [7:0] periph_tick_low, periph_tick_high, orl, orh;
  int n_errors, num_checks, c_mast, c_cpu, c_mem, c_per, c_out, c_cap, c_slow;

  cpcc_osc_model i_osc (.clock(clock), .rst_n(rst_n), .run_en(osc_en),
    .src_tick(src_tick), .src_ready(src_ready));
  // Short monitor limit keeps the failure case quick
  cpcc_top #(.FAIL_LIMIT(8)) i_dut (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_tick(src_tick),
    .src_ready(src_ready), .irq_internal(irq_internal), .irq_external(irq_external),
    .awu_irq(awu_irq), .master_clock_tick(master_clock_tick), .cpu_tick(cpu_tick),
    .mem_tick(mem_tick), .periph_tick_low(periph_tick_low),
    .periph_tick_high(periph_tick_high), .clock_output(clock_output),
    .regulator_on(regulator_on), .slow_rc_to_capture(slow_rc_to_capture),
    .clock_fail(clock_fail));

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task tally_and_finish;
    if (n_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Counts may slip by one at window edges
  task near(input int got, input int exp);
    chk(32'(got >= exp - 1 && got <= exp + 1), 32'h1);
  endtask

  // One APB transfer; request held until pready seen high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_errors++;
      tally_and_finish();
    end
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Data lives in the low byte
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_v & 32'h0000_00FF, exp);
  endtask

  // Poll until no switch is pending
  task wait_busy;
    int i;
    for (i = 0; i < 200; i++) begin
      apb(1'b0, REG_STAT, 32'h0);
      if (rd_v[STAT_BUSY_BIT] === 1'b0) break;
    end
    if (i == 200) begin
      n_errors++;
      tally_and_finish();
    end
  endtask

  // Count output activity over a window
  task run(input int n);
    logic po;
    {c_mast, c_cpu, c_mem, c_per, c_out, c_cap, c_slow} = '0;
    orl = 8'h00;
    orh = 8'h00;
    // Outputs lag a register write by two edges; skip them
    repeat (2) @(posedge clock);
    po = clock_output;
    repeat (n) begin
      @(posedge clock);
      c_mast += master_clock_tick;
      c_cpu += cpu_tick;
      c_mem += mem_tick;
      c_per += (periph_tick_low != 8'h00);
      c_out += (clock_output != po);
      po = clock_output;
      c_cap += slow_rc_to_capture;
      c_slow += src_tick[3];
      orl |= periph_tick_low;
      orh |= periph_tick_high;
    end
  endtask

  // Whole run is bounded
  initial begin
    repeat (100000) @(posedge clock);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    {rst_n, psel, penable, pwrite, irq_internal, irq_external, awu_irq} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    osc_en = 4'hD;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    // Reset state
    rdc(REG_SEL, SEL_RST);
    rdc(REG_PRESC, PRESC_RST);
    rdc(REG_STAT, 32'h0);
    rdc(REG_GATE_LO, GATE_LO_RST);
    rdc(REG_GATE_HI, GATE_HI_RST);
    chk(regulator_on, 1'b1);
    run(256);
    near(c_mast, 16);
    // Prescaler sweep over fast RC
    for (int e = 0; e < 5; e++) begin
      wr(REG_PRESC, e);
      rdc(REG_PRESC, e);
      run(256);
      near(c_mast, 128 >> e);
    end
    wr(REG_PRESC, 32'h0);
    // Gates with reserved bits
    wr(REG_GATE_LO, 32'hFF);
    rdc(REG_GATE_LO, 32'hFB);
    wr(REG_GATE_HI, 32'hFF);
    rdc(REG_GATE_HI, 32'h0C);
    run(64);
    chk({orh, orl}, 16'h0CFB);
    wr(REG_GATE_LO, 32'h10);
    run(64);
    chk(orl, 8'h10);
    // Memory stop leaves the core running
    wr(REG_SEL, 1 << SEL_MEM_OFF_BIT);
    run(64);
    chk(c_mem, 0);
    near(c_cpu, 32);
    // Clock output and slow RC to capture
    wr(REG_SEL, (1 << SEL_OUT_EN_BIT) | (1 << SEL_CAPT_BIT));
    run(256);
    near(c_out, 128);
    near(c_cap, c_slow);
    // Raw source on the output ignores a slow prescaler
    wr(REG_PRESC, 32'h3);
    wr(REG_SEL, (1 << SEL_OUT_EN_BIT) | (1 << SEL_OUT_SRC_BIT));
    run(256);
    near(c_out, 128);
    wr(REG_PRESC, 32'h0);
    wr(REG_SEL, 32'h0);
    run(32);
    chk(c_out + c_cap, 0);
    chk(clock_output, 1'b0);
    // Source switching, crystal not yet running
    wr(REG_SEL, SRC_CRYSTAL);
    run(40);
    rdc(REG_STAT, 32'h04);
    near(c_mast, 20);
    osc_en <= 4'hF;
    for (int k = 1; k < 5; k++) begin
      wr(REG_SEL, k % 4);
      wait_busy();
      rdc(REG_STAT, k % 4);
      run(96);
      near(c_mast, 96 / SPER[k % 4]);
    end
    // Crystal fails with the monitor on
    wr(REG_SEL, SRC_CRYSTAL | (1 << SEL_MON_BIT));
    wait_busy();
    wr(REG_PRESC, 32'h1);
    osc_en <= 4'hD;
    for (int i = 0; i < 64 && clock_fail !== 1'b1; i++) @(posedge clock);
    chk(clock_fail, 1'b1);
    rdc(REG_SEL, 1 << SEL_MON_BIT);
    rdc(REG_PRESC, 32'h3);
    rdc(REG_STAT, 32'h08);
    run(256);
    near(c_mast, 16);
    wr(REG_STAT, 32'h08);
    rdc(REG_STAT, 32'h0);
    // Low-power modes from user clock over four
    osc_en <= 4'hF;
    wr(REG_SEL, SRC_EXT_CLK);
    wait_busy();
    wr(REG_PRESC, 32'h2);
    for (int m = 0; m < 4; m++) begin
      wr(REG_PWR, PW[m]);
      run(4);
      run(64);
      chk(c_cpu, 0);
      chk(c_per > 0, PER_ON[m]);
      chk(regulator_on, REG_KEEP[m]);
      {awu_irq, irq_external, irq_internal} <= BAD[m];
      run(8);
      rdc(REG_STAT, {PW[m][1:0], 4'h2});
      {awu_irq, irq_external, irq_internal} <= GOOD[m];
      run(4);
      {awu_irq, irq_external, irq_internal} <= 3'h0;
      rdc(REG_STAT, 32'h2);
      rdc(REG_SEL, 32'h2);
      rdc(REG_PRESC, 32'h2);
      run(64);
      near(c_cpu, 4);
      chk(regulator_on, 1'b1);
    end
    // Unmapped offset is refused
    apb(1'b0, 8'h18, 32'h0);
    chk(er_v, 1'b1);
    chk(rd_v, 32'h0);
    tally_and_finish();
  end
endmodule
